// ===== shared/ocpwm_pkg.sv
// Purpose: constants for the two-channel output compare / pwm timer
// Assumes: ahb-lite word registers, 16-bit counter
// Notes: offsets are byte addresses of aligned words
package ocpwm_pkg;
   localparam logic [7:0] OFF_TIMER_CTRL = 8'h00;
   localparam logic [7:0] OFF_COUNT = 8'h04;
   localparam logic [7:0] OFF_PERIOD = 8'h08;
   localparam logic [7:0] OFF_CHAN0_CTRL = 8'h0C;
   localparam logic [7:0] OFF_CHAN0_CMP = 8'h10;
   localparam logic [7:0] OFF_CHAN1_CTRL = 8'h14;
   localparam logic [7:0] OFF_CHAN1_CMP = 8'h18;
   // timer control fields
   localparam int TC_FLAG = 7;
   localparam int TC_HALT = 5;
   localparam int TC_RESET = 4;
   // channel control fields
   localparam int CC_FLAG = 7;
   localparam int CC_MSB = 5;
   localparam int CC_MSA = 4;
   localparam int CC_ELB = 3;
   localparam int CC_ELA = 2;
   localparam int CC_TOV = 1;
   localparam int CC_MAX = 0;
   localparam logic [7:0] TIMER_CTRL_RST = 8'h20;
   localparam logic [15:0] PERIOD_RST = 16'hFFFF;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [2:0] PS_EXT = 3'h7;
   typedef enum logic [1:0] {ph_idle, ph_write, ph_read} bus_phase_t;
endpackage

// ===== rtl/ocpwm_prescaler.sv
// Purpose: divides bus clock into counter ticks
// Assumes: ext_clk_in synchronous to hclk
// Notes: select 7 picks external clock rising edges
`timescale 1ns/100ps
module ocpwm_prescaler #(
   parameter int DIV_W = 6
) (
   input wire logic hclk, // bus clock
   input wire logic hresetn, // async reset, low
   input wire logic clk_en, // freeze when low
   input wire logic clear, // restart prescaler
   input wire logic [2:0] sel, // divide select
   input wire logic ext_clk_in, // external timer clock
   output logic tick // counter tick
);
   import ocpwm_pkg::*;
   logic [DIV_W-1:0] div;
   logic ext_prev;
   logic [DIV_W-1:0] mask;
   always_comb begin
      mask = DIV_W'((1 << sel) - 1);
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div <= '0;
         ext_prev <= 1'b0;
      end else if (clk_en) begin
         ext_prev <= ext_clk_in;
         if (clear) begin
            div <= '0;
         end else begin
            div <= DIV_W'(div + 1'b1);
         end
      end
   end
   always_comb begin
      if (sel == PS_EXT) begin
         tick = clk_en && !clear && ext_clk_in && !ext_prev;
      end else begin
         tick = clk_en && !clear && ((div & mask) == mask);
      end
   end
endmodule

// ===== rtl/ocpwm_timer.sv
// Purpose: 16-bit timer with two compare channels and linked buffered pwm
// Assumes: one ahb-lite slave, zero wait states, okay only
// Notes: counter wraps to zero after matching period_limit
`timescale 1ns/100ps
module ocpwm_timer #(
   parameter int CNT_W = 16
) (
   input wire logic hclk, // bus clock
   input wire logic hresetn, // async reset, low
   input wire logic clk_en, // freezes all state when low
   input wire logic hsel, // slave select
   input wire logic [7:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write
   input wire logic [2:0] hsize, // size, word only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // always ready
   output logic hresp, // always okay
   input wire logic ext_clk_in, // external timer clock
   output logic chan0_pin, // channel 0 output
   output logic chan1_pin, // channel 1 output
   output logic chan1_pin_oe // high while chan1 drives pin
);
   import ocpwm_pkg::*;
   logic [7:0] timer_ctrl_status;
   logic [2:0] presc_sel;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] period_limit;
   logic [7:0] chan0_ctrl_status;
   logic [7:0] chan1_ctrl_status;
   logic [CNT_W-1:0] cmp0;
   logic [CNT_W-1:0] cmp1;
   logic last_wr1;
   logic active1;
   logic tick;
   logic ovf;
   logic match0;
   logic match1;
   logic [CNT_W-1:0] act_cmp;
   logic [CNT_W-1:0] next_count;
   logic chan0_link_select;
   logic [7:0] addr_q;
   bus_phase_t phase;
   logic wr_tc;
   logic wr_per;
   logic wr_c0;
   logic wr_c1;
   logic wr_cmp0;
   logic wr_cmp1;
   logic rd_tc;
   logic rd_c0;
   logic rd_c1;
   logic tc_armed;
   logic c0_armed;
   logic c1_armed;
   logic [CNT_W-1:0] wdat;

   function automatic logic pin_next(input logic [7:0] cc, input logic cur,
                                     input logic ov, input logic mt);
      logic v;
      v = cur;
      if (ov && cc[CC_TOV]) begin
         v = !v;
      end
      if (mt) begin
         case ({cc[CC_ELB], cc[CC_ELA]})
            2'b01: v = !v;
            2'b10: v = 1'b0;
            2'b11: v = 1'b1;
            default: v = v;
         endcase
      end
      if (cc[CC_TOV] && cc[CC_MAX]) begin
         v = 1'b1;
      end
      return v;
   endfunction

   // address phase capture; zero-wait data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase <= ph_idle;
         addr_q <= 8'h00;
      end else if (clk_en && hready) begin
         if (hsel && htrans[1]) begin
            phase <= hwrite ? ph_write : ph_read;
            addr_q <= haddr;
         end else begin
            phase <= ph_idle;
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wdat = hwdata[CNT_W-1:0];
   assign wr_tc = clk_en && phase == ph_write && addr_q == OFF_TIMER_CTRL;
   assign wr_per = clk_en && phase == ph_write && addr_q == OFF_PERIOD;
   assign wr_c0 = clk_en && phase == ph_write && addr_q == OFF_CHAN0_CTRL;
   assign wr_c1 = clk_en && phase == ph_write && addr_q == OFF_CHAN1_CTRL;
   assign wr_cmp0 = clk_en && phase == ph_write && addr_q == OFF_CHAN0_CMP;
   assign wr_cmp1 = clk_en && phase == ph_write && addr_q == OFF_CHAN1_CMP;
   assign rd_tc = clk_en && phase == ph_read && addr_q == OFF_TIMER_CTRL;
   assign rd_c0 = clk_en && phase == ph_read && addr_q == OFF_CHAN0_CTRL;
   assign rd_c1 = clk_en && phase == ph_read && addr_q == OFF_CHAN1_CTRL;
   assign chan0_link_select = chan0_ctrl_status[CC_MSB];

   ocpwm_prescaler #(.DIV_W(6)) u_presc (
      .hclk(hclk),
      .hresetn(hresetn),
      .clk_en(clk_en),
      .clear(wr_tc && hwdata[TC_RESET]),
      .sel(presc_sel),
      .ext_clk_in(ext_clk_in),
      .tick(tick)
   );

   // ticks only while running; one compare per tick
   assign ovf = tick && !timer_ctrl_status[TC_HALT] && count == period_limit;
   assign act_cmp = (chan0_link_select && active1) ? cmp1 : cmp0;
   // compare acts as the counter lands on the value, in step with the wrap,
   // so the pulse spans exactly the compare value in ticks
   assign next_count = (count == period_limit) ? COUNT_RST : CNT_W'(count + 1'b1);
   assign match0 = tick && !timer_ctrl_status[TC_HALT] && next_count == act_cmp;
   assign match1 = tick && !timer_ctrl_status[TC_HALT] && next_count == cmp1
                   && !chan0_link_select;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= COUNT_RST;
      end else if (clk_en) begin
         if (wr_tc && hwdata[TC_RESET]) begin
            count <= COUNT_RST;
         end else if (ovf) begin
            count <= COUNT_RST;
         end else if (tick && !timer_ctrl_status[TC_HALT]) begin
            count <= CNT_W'(count + 1'b1);
         end
      end
   end

   // flags: set wins over clear; clear needs prior read with flag set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_ctrl_status <= TIMER_CTRL_RST;
         presc_sel <= 3'h0;
         tc_armed <= 1'b0;
      end else if (clk_en) begin
         if (rd_tc) begin
            tc_armed <= timer_ctrl_status[TC_FLAG];
         end
         if (wr_tc) begin
            timer_ctrl_status[6:5] <= hwdata[6:5];
            presc_sel <= hwdata[2:0];
            if (!hwdata[TC_FLAG] && tc_armed) begin
               timer_ctrl_status[TC_FLAG] <= 1'b0;
               tc_armed <= 1'b0;
            end
         end
         if (ovf) begin
            timer_ctrl_status[TC_FLAG] <= 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chan0_ctrl_status <= 8'h00;
         chan1_ctrl_status <= 8'h00;
         c0_armed <= 1'b0;
         c1_armed <= 1'b0;
      end else if (clk_en) begin
         if (rd_c0) begin
            c0_armed <= chan0_ctrl_status[CC_FLAG];
         end
         if (rd_c1) begin
            c1_armed <= chan1_ctrl_status[CC_FLAG];
         end
         if (wr_c0) begin
            chan0_ctrl_status[6:0] <= hwdata[6:0];
            if (!hwdata[CC_FLAG] && c0_armed) begin
               chan0_ctrl_status[CC_FLAG] <= 1'b0;
               c0_armed <= 1'b0;
            end
         end
         if (wr_c1) begin
            chan1_ctrl_status[6:0] <= {hwdata[6], 1'b0, hwdata[4:0]};
            if (!hwdata[CC_FLAG] && c1_armed) begin
               chan1_ctrl_status[CC_FLAG] <= 1'b0;
               c1_armed <= 1'b0;
            end
         end
         if (match0) begin
            chan0_ctrl_status[CC_FLAG] <= 1'b1;
         end
         if (match1) begin
            chan1_ctrl_status[CC_FLAG] <= 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         period_limit <= PERIOD_RST;
         cmp0 <= '0;
         cmp1 <= '0;
      end else if (clk_en) begin
         if (wr_per) begin
            period_limit <= wdat;
         end
         if (wr_cmp0) begin
            cmp0 <= wdat;
         end
         if (wr_cmp1) begin
            cmp1 <= wdat;
         end
      end
   end

   // last-written record, latched to active pair at overflow
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_wr1 <= 1'b0;
         active1 <= 1'b0;
      end else if (clk_en) begin
         if (wr_cmp1) begin
            last_wr1 <= 1'b1;
         end else if (wr_cmp0) begin
            last_wr1 <= 1'b0;
         end
         if (!chan0_link_select) begin
            active1 <= 1'b0;
         end else if (ovf) begin
            active1 <= last_wr1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chan0_pin <= 1'b0;
         chan1_pin <= 1'b0;
      end else if (clk_en) begin
         if (chan0_link_select || chan0_ctrl_status[CC_MSA]) begin
            chan0_pin <= pin_next(chan0_ctrl_status, chan0_pin, ovf, match0);
         end
         if (!chan0_link_select && chan1_ctrl_status[CC_MSA]) begin
            chan1_pin <= pin_next(chan1_ctrl_status, chan1_pin, ovf, match1);
         end
      end
   end
   assign chan1_pin_oe = !chan0_link_select && chan1_ctrl_status[CC_MSA];

   always_comb begin
      hrdata = 32'h0000_0000;
      if (phase == ph_read) begin
         case (addr_q)
            OFF_TIMER_CTRL: hrdata = {24'h00_0000, timer_ctrl_status[7:5], 2'b00, presc_sel};
            OFF_COUNT: hrdata = {16'h0000, count};
            OFF_PERIOD: hrdata = {16'h0000, period_limit};
            OFF_CHAN0_CTRL: hrdata = {24'h00_0000, chan0_ctrl_status};
            OFF_CHAN0_CMP: hrdata = {16'h0000, cmp0};
            OFF_CHAN1_CTRL: hrdata = {24'h00_0000, chan1_ctrl_status};
            OFF_CHAN1_CMP: hrdata = {16'h0000, cmp1};
            default: hrdata = 32'h0000_0000;
         endcase
      end
   end

   a_ovf_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      ovf && clk_en |=> timer_ctrl_status[TC_FLAG]) else $error("overflow flag missed");
   a_ovf_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
      ovf && clk_en && !wr_tc |=> count == '0) else $error("counter did not wrap");
   a_match_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      match0 && clk_en |=> chan0_ctrl_status[CC_FLAG]) else $error("match flag missed");
   a_clear_low: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && match0 && !ovf && chan0_ctrl_status[3:0] == 4'b1000 && chan0_ctrl_status[CC_MSA]
      |=> !chan0_pin) else $error("clear on compare failed");
   a_set_high: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && match0 && !ovf && chan0_ctrl_status[3:2] == 2'b11 && chan0_ctrl_status[CC_MSA]
      |=> chan0_pin) else $error("set on compare failed");
   a_max_duty: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && chan0_ctrl_status[CC_TOV] && chan0_ctrl_status[CC_MAX] && chan0_link_select
      |=> chan0_pin) else $error("max duty not held");
   a_active_swap: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && !ovf && chan0_link_select && !$past(!chan0_link_select) |=> $stable(active1))
      else $error("active pair changed mid period");
   a_rst_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_tc && hwdata[TC_RESET] |=> count == '0) else $error("counter reset failed");
   a_link_oe: assert property (@(posedge hclk) disable iff (!hresetn)
      chan0_link_select |-> !chan1_pin_oe) else $error("chan1 pin driven while linked");
   c_ovf: cover property (@(posedge hclk) disable iff (!hresetn) ovf);
   c_swap: cover property (@(posedge hclk) disable iff (!hresetn) ovf && last_wr1 && !active1);
   c_match: cover property (@(posedge hclk) disable iff (!hresetn) match0 && chan0_link_select);
endmodule

// ===== bench/pwm_meter.sv
// Purpose: load on the channel pin that times its pulses
// Assumes: pin sampled on hclk, same clock as the timer
// Notes: times in hclk cycles; push-pull pin, never released
`timescale 1ns/100ps
module pwm_meter (
   input wire logic hclk, // sampling clock
   input wire logic pin, // observed channel output
   output int high_len, // last completed high time
   output int period_len, // last rise to rise time
   output int falls // falling edges seen
);
   int high_run = 0;
   int since_rise = 0;
   logic last_pin = 1'h0;
   initial begin
      high_len = 0;
      period_len = 0;
      falls = 0;
   end
   always @(posedge hclk) begin
      last_pin <= pin;
      since_rise <= since_rise + 1;
      if (pin === 1'h1) high_run <= high_run + 1;
      // first high sample restarts both measurements
      if (pin === 1'h1 && last_pin === 1'h0) begin
         period_len <= since_rise;
         since_rise <= 1;
         high_run <= 1;
      end
      if (pin === 1'h0 && last_pin === 1'h1) begin
         high_len <= high_run;
         falls <= falls + 1;
      end
   end
endmodule

// ===== bench/testbench.sv
// Purpose: register-level tests of the two-channel compare / pwm timer
// Assumes: zero-wait slave, prescale 0 so one counter tick per hclk, except the end of the last test, which divides by two
// Notes: pulse timing comes from the pin meter, never from the timer
`timescale 1ns/100ps
module testbench;
   import ocpwm_pkg::*;
   logic hclk = 1'h0;
   logic hresetn = 1'h0;
   logic hsel = 1'h0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic clk_en = 1'h1;
   wire logic hready;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic chan0_pin;
   logic chan1_pin;
   logic chan1_pin_oe;
   logic [31:0] rd;
   logic [31:0] saved;
   int errors = 0;
   int total_checks = 0;
   int high_len;
   int period_len;
   int falls;
   assign hready = hreadyout;
   always #2 hclk = ~hclk;
   ocpwm_timer u_ocpwm_timer (
      .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .ext_clk_in(1'h0), .chan0_pin(chan0_pin), .chan1_pin(chan1_pin),
      .chan1_pin_oe(chan1_pin_oe)
   );
   pwm_meter u_pwm_meter (
      .hclk(hclk), .pin(chan0_pin), .high_len(high_len), .period_len(period_len),
      .falls(falls)
   );
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'h1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
   endtask
   task automatic rdck(input string name, input logic [7:0] a, input logic [31:0] exp);
      bus(1'h0, a, 32'h0000_0000);
      check(name, rd, exp);
   endtask
   // polls need a window of at least three counts: one read spans three cycles
   task automatic count_to(input logic [31:0] lo, input logic [31:0] hi);
      int i;
      i = 0;
      bus(1'h0, OFF_COUNT, 32'h0000_0000);
      while ((rd < lo || rd > hi) && i < 400) begin
         bus(1'h0, OFF_COUNT, 32'h0000_0000);
         i++;
      end
   endtask
   task automatic wait_fall(input int n);
      int f;
      f = falls;
      for (int i = 0; i < 3000 && falls < f + n; i++) @(posedge hclk);
      check("fall_wait", falls >= f + n, 32'h0000_0001);
   endtask
   task automatic hold_level(input logic lvl);
      int bad;
      bad = 0;
      repeat (300) @(posedge hclk);
      repeat (520) begin
         @(posedge hclk);
         if (chan0_pin !== lvl) bad++;
      end
      check("pin_hold", bad, 32'h0000_0000);
   endtask
   task automatic pwm_setup(input logic [31:0] per, input logic [31:0] cmp,
                            input logic [31:0] ctl);
      wr(OFF_TIMER_CTRL, 32'h0000_0020);
      wr(OFF_TIMER_CTRL, 32'h0000_0030);
      wr(OFF_PERIOD, per);
      wr(OFF_CHAN0_CMP, cmp);
      wr(OFF_CHAN0_CTRL, ctl);
      wr(OFF_TIMER_CTRL, 32'h0000_0000);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'h1;
      rdck("timer_ctrl", OFF_TIMER_CTRL, {24'h00_0000, TIMER_CTRL_RST});
      rdck("period", OFF_PERIOD, {16'h0000, PERIOD_RST});
      rdck("count", OFF_COUNT, {16'h0000, COUNT_RST});
      rdck("chan0_ctrl", OFF_CHAN0_CTRL, 32'h0000_0000);
      wr(8'h1C, 32'h0000_00FF);
      rdck("unmapped", 8'h1C, 32'h0000_0000);
      $display("test reset done");
      // high pulse: toggle on overflow, clear on compare, mode 0:1
      pwm_setup(32'h0000_00FF, 32'h0000_0080, 32'h0000_001A);
      wait_fall(3);
      check("pwm_period", period_len, 32'h0000_0100);
      check("pwm_high", high_len, 32'h0000_0080);
      rdck("ovf_set", OFF_TIMER_CTRL, 32'h0000_0080);
      wr(OFF_TIMER_CTRL, 32'h0000_0020);
      rdck("ovf_clear", OFF_TIMER_CTRL, 32'h0000_0020);
      bus(1'h0, OFF_COUNT, 32'h0000_0000);
      saved = rd;
      rdck("halted", OFF_COUNT, saved);
      wr(OFF_TIMER_CTRL, 32'h0000_0030);
      rdck("cnt_reset", OFF_COUNT, 32'h0000_0000);
      rdck("rst_selfclr", OFF_TIMER_CTRL, 32'h0000_0020);
      $display("test pwm done");
      pwm_setup(32'h0000_00FF, 32'h0000_0080, 32'h0000_0018);
      hold_level(1'h0);
      wr(OFF_CHAN0_CTRL, 32'h0000_001B);
      hold_level(1'h1);
      // freeze 100 cycles: only the four running edges around it count
      bus(1'h0, OFF_COUNT, 32'h0000_0000);
      saved = rd;
      @(posedge hclk);
      clk_en <= 1'h0;
      repeat (100) @(posedge hclk);
      clk_en <= 1'h1;
      rdck("frozen", OFF_COUNT, (saved + 32'h0000_0004) & 32'h0000_00FF);
      $display("test duty limits done");
      pwm_setup(32'h0000_00FF, 32'h0000_00C8, 32'h0000_0018);
      count_to(32'h0000_00D2, 32'h0000_00E6);
      check("cleared", chan0_pin, 1'h0);
      wr(OFF_CHAN0_CTRL, 32'h0000_001C);
      count_to(32'h0000_0014, 32'h0000_0028);
      // new value already passed and the old one replaced
      wr(OFF_CHAN0_CMP, 32'h0000_000A);
      count_to(32'h0000_00E6, 32'h0000_00FA);
      check("no_match", chan0_pin, 1'h0);
      count_to(32'h0000_001E, 32'h0000_0032);
      check("set_match", chan0_pin, 1'h1);
      rdck("chan0_flag", OFF_CHAN0_CTRL, 32'h0000_009C);
      wr(OFF_CHAN0_CTRL, 32'h0000_0014);
      repeat (256) @(posedge hclk);
      check("toggled", chan0_pin, 1'h0);
      $display("test unbuffered done");
      // linked pair, mode 1:0 through the link bit
      pwm_setup(32'h0000_00FF, 32'h0000_0040, 32'h0000_002A);
      wr(OFF_CHAN1_CTRL, 32'h0000_001C);
      wait_fall(3);
      check("linked_high", high_len, 32'h0000_0040);
      check("chan1_oe", chan1_pin_oe, 1'h0);
      count_to(32'h0000_0014, 32'h0000_0028);
      wr(OFF_CHAN1_CMP, 32'h0000_00C0);
      wait_fall(1);
      check("same_period", high_len, 32'h0000_0040);
      wait_fall(1);
      check("chan1_high", high_len, 32'h0000_00C0);
      wr(OFF_CHAN0_CMP, 32'h0000_0020);
      wait_fall(1);
      check("chan0_again", high_len, 32'h0000_0020);
      // prescale by two doubles both period and width in hclk cycles
      wr(OFF_TIMER_CTRL, 32'h0000_0001);
      wait_fall(2);
      check("div2_period", period_len, 32'h0000_0200);
      check("div2_high", high_len, 32'h0000_0040);
      $display("test buffered done");
      final_report;
   end
   initial begin
      repeat (40000) @(posedge hclk);
      errors++;
      final_report;
   end
endmodule
